// File: src/rx_run_pkg.sv
// =====================================================================
// shared constants and carriers for the receiver run control block
package rx_run_pkg;
    // width of a receive data word and a status word
    localparam int DATA_W = 32;
    // default depths of the receive data and status fifos, in words
    localparam int DATA_DEPTH = 16;
    localparam int STAT_DEPTH = 4;
    // reset value of the fifo read data outputs
    localparam logic [DATA_W-1:0] WORD_RST = 32'h0000_0000;

    // run state of the receiver
    typedef enum logic [1:0] {
        RUN_IDLE,
        RUN_FRAME,
        RUN_HALT
    } run_state_t;

    // one word coming from the receive mac side
    typedef struct packed {
        logic valid;
        logic last;
        logic [DATA_W-1:0] data;
    } rx_word_t;

    // one status word at the end of a frame
    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] status;
    } rx_status_t;
endpackage : rx_run_pkg

// File: src/mac_receiver_run_control.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// receiver run control with data and status fifos
module mac_receiver_run_control
    import rx_run_pkg::*;
#(
    parameter int DDEPTH = DATA_DEPTH,  // data fifo words
    parameter int SDEPTH = STAT_DEPTH   // status fifo words
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // receive enable bit from mac control
    input wire logic receive_enable_bit_i,
    // words and status from the receive mac
    input wire rx_word_t rx_word_i,
    input wire rx_status_t rx_status_i,
    // host fifo reads
    input wire logic data_rd_i,
    input wire logic stat_rd_i,
    // host flushes, honoured only while halted
    input wire logic data_flush_i,
    input wire logic stat_flush_i,
    // host acknowledge of the error flag
    input wire logic error_ack_i,
    output logic [DATA_W-1:0] data_rdata_o,
    output logic [DATA_W-1:0] stat_rdata_o,
    output logic data_empty_o,
    output logic stat_empty_o,
    output logic receiver_stopped_event_o,
    output logic receiver_error_flag_o,
    output logic halted_o
);
    // =================================================================
    // pointer widths
    // depths that are not powers of two still wrap by compare
    localparam int DAW = $clog2(DDEPTH);
    localparam int SAW = $clog2(SDEPTH);

    // storage arrays
    logic [DATA_W-1:0] dmem_q [DDEPTH];
    logic [DATA_W-1:0] smem_q [SDEPTH];
    // pointers and fill counts
    logic [DAW-1:0] dwp_q, drp_q;
    logic [SAW-1:0] swp_q, srp_q;
    logic [DAW:0] dcnt_q;
    logic [SAW:0] scnt_q;
    run_state_t state_q;
    logic halt_seen_q;      // stopped event already sent
    logic drop_q;           // rest of frame dropped after data overflow

    // =================================================================
    // run control
    // a frame in flight is allowed to finish before halting so the
    // status fifo never holds a frame cut in half
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_q <= RUN_IDLE;
        end else begin
            case (state_q)
                RUN_IDLE: begin
                    // a word already on its way opens a frame first so
                    // its status word is never shut out by the halt
                    if (rx_word_i.valid) begin
                        state_q <= RUN_FRAME;
                    end else if (!receive_enable_bit_i) begin
                        state_q <= RUN_HALT;
                    end
                end
                RUN_FRAME: begin
                    // frame ends on its status word
                    if (rx_status_i.valid) begin
                        state_q <= receive_enable_bit_i ? RUN_IDLE : RUN_HALT;
                    end
                end
                RUN_HALT: begin
                    // no self restart
                    if (receive_enable_bit_i) begin
                        state_q <= RUN_IDLE;
                    end
                end
                default: state_q <= RUN_IDLE;
            endcase
        end
    end

    // halt flag and single stopped pulse
    // the pulse is registered so it never glitches on a state change
    logic halted;
    assign halted = (state_q == RUN_HALT);
    assign halted_o = halted;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            halt_seen_q <= 1'b0;
            receiver_stopped_event_o <= 1'b0;
        end else begin
            // one cycle pulse in the cycle after the first halted cycle
            receiver_stopped_event_o <= halted && !halt_seen_q;
            halt_seen_q <= halted;
        end
    end

    // =================================================================
    // fifo write and read qualifiers
    logic accept;
    logic d_full, s_full, d_empty, s_empty;
    logic d_wr, s_wr, d_rd, s_rd, d_flush, s_flush;
    assign accept = !halted;
    assign d_full = (dcnt_q == (DAW+1)'(DDEPTH));
    assign s_full = (scnt_q == (SAW+1)'(SDEPTH));
    assign d_empty = (dcnt_q == '0);
    assign s_empty = (scnt_q == '0);
    assign d_flush = data_flush_i && halted;
    assign s_flush = stat_flush_i && halted;
    assign d_wr = accept && rx_word_i.valid && !d_full && !drop_q;
    assign s_wr = accept && rx_status_i.valid && !s_full;
    assign d_rd = data_rd_i && !d_empty;
    assign s_rd = stat_rd_i && !s_empty;
    assign data_empty_o = d_empty;
    assign stat_empty_o = s_empty;

    // drop the remainder of a frame once the data fifo overflowed
    // trade-off: an overflowing frame loses its tail, not older frames
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            drop_q <= 1'b0;
        end else if (rx_word_i.valid && rx_word_i.last) begin
            drop_q <= 1'b0;
        end else if (accept && rx_word_i.valid && d_full) begin
            drop_q <= 1'b1;
        end
    end

    // =================================================================
    // data fifo
    // storage has no reset; only the pointers say what is valid
    always_ff @(posedge clk_i) begin
        if (d_wr) begin
            dmem_q[dwp_q] <= rx_word_i.data;
        end
    end

    always_ff @(posedge clk_i) begin
        // a flush rewinds the pointers and clears the last word
        if (sys_rst_i || d_flush) begin
            dwp_q <= '0;
            drp_q <= '0;
            dcnt_q <= '0;
            data_rdata_o <= WORD_RST;
        end else begin
            if (d_wr) begin
                dwp_q <= (dwp_q == DAW'(DDEPTH-1)) ? '0 : dwp_q + 1'b1;
            end
            if (d_rd) begin
                drp_q <= (drp_q == DAW'(DDEPTH-1)) ? '0 : drp_q + 1'b1;
                data_rdata_o <= dmem_q[drp_q];
            end
            dcnt_q <= dcnt_q + (DAW+1)'(d_wr) - (DAW+1)'(d_rd);
        end
    end

    // =================================================================
    // status fifo
    // same shape as the data fifo, sized for status words
    always_ff @(posedge clk_i) begin
        if (s_wr) begin
            smem_q[swp_q] <= rx_status_i.status;
        end
    end

    always_ff @(posedge clk_i) begin
        // a full status fifo refuses the write; the error flag reports it
        if (sys_rst_i || s_flush) begin
            swp_q <= '0;
            srp_q <= '0;
            scnt_q <= '0;
            stat_rdata_o <= WORD_RST;
        end else begin
            if (s_wr) begin
                swp_q <= (swp_q == SAW'(SDEPTH-1)) ? '0 : swp_q + 1'b1;
            end
            if (s_rd) begin
                srp_q <= (srp_q == SAW'(SDEPTH-1)) ? '0 : srp_q + 1'b1;
                stat_rdata_o <= smem_q[srp_q];
            end
            scnt_q <= scnt_q + (SAW+1)'(s_wr) - (SAW+1)'(s_rd);
        end
    end

    // =================================================================
    // sticky error flag; a new cause wins over the acknowledge
    // the flag feeds nothing in the run control, so reception goes on
    // limitation: the flag alone does not tell the host the cause
    logic err_set;
    assign err_set = (data_rd_i && d_empty)
                   || (stat_rd_i && s_empty)
                   || (accept && rx_status_i.valid && s_full);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            receiver_error_flag_o <= 1'b0;
        end else if (err_set) begin
            receiver_error_flag_o <= 1'b1;
        end else if (error_ack_i) begin
            receiver_error_flag_o <= 1'b0;
        end
    end
endmodule : mac_receiver_run_control
`default_nettype wire

// File: verification/rx_run_properties.sv
`timescale 1ns/1ps
`default_nettype none
// =====
// port checks of the run control block
module rx_run_properties (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic receive_enable_bit_i,
    input wire logic data_rd_i,
    input wire logic stat_rd_i,
    input wire logic error_ack_i,
    input wire logic data_empty_o,
    input wire logic stat_empty_o,
    input wire logic receiver_stopped_event_o,
    input wire logic receiver_error_flag_o,
    input wire logic halted_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    chk_stop_pulse: assert property ($rose(halted_o)
        |=> receiver_stopped_event_o) else $error("no stop pulse");
    chk_one_pulse: assert property (receiver_stopped_event_o
        |=> !receiver_stopped_event_o) else $error("long stop pulse");
    chk_pulse_cause: assert property (receiver_stopped_event_o
        |-> $past(halted_o)) else $error("pulse without halt");
    chk_data_under: assert property (data_rd_i && data_empty_o
        |=> receiver_error_flag_o) else $error("data underrun missed");
    chk_stat_under: assert property (stat_rd_i && stat_empty_o
        |=> receiver_error_flag_o) else $error("stat underrun missed");
    chk_err_sticky: assert property (receiver_error_flag_o
        && !error_ack_i |=> receiver_error_flag_o) else $error("flag lost");
    // enable seen on two edges so a halt already under way is excused
    chk_err_runs: assert property (receiver_error_flag_o &&
        receive_enable_bit_i && $past(receive_enable_bit_i) && !halted_o
        |=> !halted_o) else $error("error halted receiver");
    chk_halt_hold: assert property (halted_o && data_empty_o
        && stat_empty_o |=> data_empty_o && stat_empty_o)
        else $error("write while halted");
endmodule : rx_run_properties
bind mac_receiver_run_control rx_run_properties u_chk (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .data_rd_i(data_rd_i),
    .receive_enable_bit_i(receive_enable_bit_i), .stat_rd_i(stat_rd_i),
    .error_ack_i(error_ack_i), .data_empty_o(data_empty_o),
    .stat_empty_o(stat_empty_o), .halted_o(halted_o),
    .receiver_stopped_event_o(receiver_stopped_event_o),
    .receiver_error_flag_o(receiver_error_flag_o));
`default_nettype wire

// File: verification/host_model.sv
`timescale 1ns/1ps
`default_nettype none
// =====
// host cpu side: mac control enable bit and one-cycle fifo strobes
module host_model (
    // bench request: en, ack, sflush, dflush, srd, drd
    input wire logic [5:0] req_i,
    output logic en_o,
    output logic data_rd_o,
    output logic stat_rd_o,
    output logic data_flush_o,
    output logic stat_flush_o,
    output logic ack_o
);
    // the host changes these just after an edge from its own code,
    // so they need no further timing here
    assign {en_o, ack_o, stat_flush_o, data_flush_o, stat_rd_o,
        data_rd_o} = req_i;
endmodule : host_model
`default_nettype wire

// File: verification/test_mac_receiver_run_control.sv
`timescale 1ns/1ps
`default_nettype none
// =====
// bench: overrun, stop and flush, underruns
module test_mac_receiver_run_control;
    import rx_run_pkg::*;
    localparam int SD = 2; // short status fifo reaches overrun fast
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    rx_word_t word = '0;
    rx_status_t stat = '0;
    logic [5:0] hreq = 6'h20; // en, ack, sflush, dflush, srd, drd
    wire logic en, drd, srd, dfl, sfl, ack;
    logic [DATA_W-1:0] drdata, srdata;
    logic dempty, sempty, stop, err, halted;
    int bad_count = 0;
    int checks_done = 0;
    mac_receiver_run_control #(.SDEPTH(SD)) u_mac_receiver_run_control (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .receive_enable_bit_i(en),
        .rx_word_i(word), .rx_status_i(stat), .data_rd_i(drd),
        .stat_rd_i(srd), .data_flush_i(dfl), .stat_flush_i(sfl),
        .error_ack_i(ack), .data_rdata_o(drdata), .stat_rdata_o(srdata),
        .data_empty_o(dempty), .stat_empty_o(sempty), .halted_o(halted),
        .receiver_stopped_event_o(stop), .receiver_error_flag_o(err));
    host_model u_host_model (.req_i(hreq), .en_o(en), .data_rd_o(drd),
        .stat_rd_o(srd), .data_flush_o(dfl), .stat_flush_o(sfl),
        .ack_o(ack));
    initial forever #5 clk_i = ~clk_i;
    task automatic cmp(input string n, input logic [DATA_W-1:0] e, s);
        checks_done++;
        if (s !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : cmp
    // one-word frame; idle data is inverted, not left at its last value
    task automatic send(input logic [DATA_W-1:0] w);
        @(posedge clk_i) #1 word = '{1'b1, 1'b1, w};
        @(posedge clk_i) #1 word = '{1'b0, 1'b0, ~w};
        stat = '{1'b1, w};
        @(posedge clk_i) #1 stat = '{1'b0, ~w};
        @(posedge clk_i) #1;
    endtask : send
    // host strobes held one full cycle so exactly one edge sees them
    task automatic strobe(input logic [4:0] r);
        @(posedge clk_i) #1 hreq[4:0] = r;
        @(posedge clk_i) #1 hreq[4:0] = 5'h00;
    endtask : strobe
    // the enable bit only moves when the host writes it
    task automatic set_en(input logic v);
        @(posedge clk_i) #1 hreq[5] = v;
    endtask : set_en
    task automatic s_overrun();
        for (int i = 0; i <= SD; i++) begin
            send(32'h0000_00A0 + 32'(i));
        end
        cmp("overrun flag", 32'h1, err);
        cmp("halted", 32'h0, halted);
        for (int i = 0; i < SD; i++) begin
            strobe(5'h02);
            cmp("status", 32'h0000_00A0 + 32'(i), srdata);
        end
        cmp("stat drained", 32'h1, sempty);
        strobe(5'h10);
        cmp("acked flag", 32'h0, err);
    endtask : s_overrun
    task automatic s_stop();
        set_en(1'b0);
        for (int i = 0; i < 20 && halted !== 1'b1; i++) @(posedge clk_i) #1;
        cmp("halted", 32'h1, halted);
        @(posedge clk_i) #1 cmp("pulse", 32'h1, stop);
        strobe(5'h0C);
        cmp("flushed", 32'h3, {dempty, sempty});
        send(32'h5A5A_5A5A);
        cmp("halt empty", 32'h3, {dempty, sempty});
        set_en(1'b1);
        @(posedge clk_i) #1 cmp("restart", 32'h0, halted);
    endtask : s_stop
    task automatic s_under();
        strobe(5'h02);
        cmp("stat under", 32'h1, err);
        repeat (3) @(posedge clk_i);
        #1 cmp("sticky", 32'h1, err);
        strobe(5'h12);
        cmp("set wins", 32'h1, err);
        strobe(5'h10);
        cmp("acked", 32'h0, err);
        strobe(5'h01);
        cmp("data under", 32'h1, err);
        send(32'h0000_1234);
        strobe(5'h04);
        cmp("no flush", 32'h0, dempty);
        strobe(5'h01);
        cmp("word", 32'h0000_1234, drdata);
        cmp("running", 32'h0, halted);
    endtask : s_under
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict
    // whole run is under a hundred cycles
    initial begin
        #(5000 * 10);
        bad_count++;
        give_verdict();
    end
    initial begin
        repeat (16) @(posedge clk_i);
        #1 sys_rst_i = 1'b0;
        s_overrun();
        s_stop();
        s_under();
        give_verdict();
    end
endmodule : test_mac_receiver_run_control
`default_nettype wire
